/* File: core/supply_supervisor_watchdog.sv */
// Supervisory logic of a processor supply regulator: power-up hold,
// watchdog with periodic restart, undervoltage reset, early warning.
// Assumes analog comparators deliver the supply levels as logic pins.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog #(
  parameter int INIT_CYCLES    = supervisor_pkg::INIT_CYCLES,
  parameter int TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYCLES,
  parameter int REINIT_CYCLES  = supervisor_pkg::REINIT_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  input  wire logic watchdog_kick,
  input  wire logic on_control,
  input  wire logic out_below_trip,
  input  wire logic out_below_release,
  input  wire logic regulator_supply_low,
  input  wire logic raw_supply_sense_low,
  output logic      reset_n,
  output logic      halt_n,
  output logic      power_fail_warn,
  output logic      regulated_output_en
);

  localparam int CW = supervisor_pkg::CNT_W;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (INIT_CYCLES < 1 || TIMEOUT_CYCLES < 1 || REINIT_CYCLES < 1) begin : g_bad_min
    $error("delay counts must be at least one cycle");
  end
  if (INIT_CYCLES >= (1 << CW) - 1 || TIMEOUT_CYCLES >= (1 << CW) - 1 ||
      REINIT_CYCLES >= (1 << CW) - 1) begin : g_bad_max
    $error("delay counts exceed the counter width");
  end
  // Restart cycle only matches its nominal figure at default counts
  if (supervisor_pkg::TIMEOUT_CYCLES + supervisor_pkg::REINIT_CYCLES !=
      supervisor_pkg::CYCLE_CYCLES) begin : g_bad_cycle
    $error("restart cycle is not timeout plus reinit");
  end

  // Limits at counter width
  localparam logic [CW-1:0] INIT_LAST    = CW'(INIT_CYCLES - 1);
  localparam logic [CW-1:0] TIMEOUT_LAST = CW'(TIMEOUT_CYCLES - 1);
  localparam logic [CW-1:0] REINIT_LAST  = CW'(REINIT_CYCLES - 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [supervisor_pkg::SYN_W-1:0] pins_raw = {
    raw_supply_sense_low,
    regulator_supply_low,
    out_below_release,
    out_below_trip,
    on_control,
    watchdog_kick
  };
  logic [supervisor_pkg::SYN_W-1:0] pins_s;

  pin_sync #(
    .W (supervisor_pkg::SYN_W)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .pin    (pins_raw),
    .level  (pins_s)
  );

  // Synchronised levels
  wire kick_s    = pins_s[supervisor_pkg::SYN_KICK];
  wire on_s      = pins_s[supervisor_pkg::SYN_ON];
  wire trip_s    = pins_s[supervisor_pkg::SYN_TRIP];
  wire release_s = pins_s[supervisor_pkg::SYN_RELEASE];
  wire adj_low_s = pins_s[supervisor_pkg::SYN_ADJ];
  wire raw_low_s = pins_s[supervisor_pkg::SYN_RAW];

  // ---------------------------------------------------------------
  // Kick edge detector
  // ---------------------------------------------------------------
  logic kick_prev_q;

  // Only a rise counts; a stuck-high kick never rearms
  wire kick_rise = kick_s & ~kick_prev_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      kick_prev_q <= 1'b0;
    end else if (clk_en) begin
      kick_prev_q <= kick_s;
    end
  end

  // ---------------------------------------------------------------
  // Output undervoltage with hysteresis
  // ---------------------------------------------------------------
  logic uv_q;

  // Trip sets, only rising above the upper level clears; set wins
  wire uv_d = trip_s | (uv_q & release_s);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      uv_q <= supervisor_pkg::RST_UV;
    end else if (clk_en) begin
      uv_q <= uv_d;
    end
  end

  // ---------------------------------------------------------------
  // Fault summary
  // ---------------------------------------------------------------
  // Standby turns the output off, so it restarts the init hold too
  wire standby = ~on_s;
  wire fault   = uv_q | adj_low_s | standby;

  // ---------------------------------------------------------------
  // Delay counter
  // ---------------------------------------------------------------
  supervisor_pkg::sup_state_type state_q;
  supervisor_pkg::sup_state_type state_d;
  logic [CW-1:0]                 elapsed;

  // ---------------------------------------------------------------
  // State decode
  // ---------------------------------------------------------------
  wire in_power_up = (state_q == supervisor_pkg::ST_POWER_UP);
  wire in_run      = (state_q == supervisor_pkg::ST_RUN);
  wire in_hold     = (state_q == supervisor_pkg::ST_WD_HOLD);
  // Kicks outside run are ignored; the processor is held then anyway
  wire run_kick    = in_run & kick_rise;

  // Span ends compare against the last count, not the length
  wire init_done = in_power_up & (elapsed == INIT_LAST);
  wire hold_done = in_hold & (elapsed == REINIT_LAST);
  // A kick in the very last cycle still counts as in time
  wire timed_out = in_run & (elapsed == TIMEOUT_LAST) & ~kick_rise;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Any fault overrides the sequence and restarts the power-up hold
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      supervisor_pkg::ST_POWER_UP: begin
        if (init_done) begin
          state_d = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (timed_out) begin
          state_d = supervisor_pkg::ST_WD_HOLD;
        end
      end
      // Leaving the hold rearms the timeout, so silence repeats the cycle
      supervisor_pkg::ST_WD_HOLD: begin
        if (hold_done) begin
          state_d = supervisor_pkg::ST_RUN;
        end
      end
      // Codes that are not one-hot fall back to the safe state
      default: begin
        state_d = supervisor_pkg::ST_POWER_UP;
      end
    endcase
    if (fault) begin
      state_d = supervisor_pkg::ST_POWER_UP;
    end
  end

  // ---------------------------------------------------------------
  // Count control
  // ---------------------------------------------------------------
  // Each state measures its own span from zero, so one counter serves all
  wire state_change = (state_d != state_q);
  wire count_clear  = fault | state_change | run_kick;

  delay_counter #(
    .W (CW)
  ) u_delay (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .clear  (count_clear),
    .count  (elapsed)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset and halt flops load what the state will be, so they switch with it
  wire run_next = (state_d == supervisor_pkg::ST_RUN);

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= supervisor_pkg::ST_POWER_UP;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Reset and halt share one source, so they cannot drift apart
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reset_n <= supervisor_pkg::RST_RESET_N;
      halt_n  <= supervisor_pkg::RST_RESET_N;
    end else if (clk_en) begin
      reset_n <= run_next;
      halt_n  <= run_next;
    end
  end

  // Warning and output enable follow their synchronised pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_fail_warn     <= supervisor_pkg::RST_WARN;
      regulated_output_en <= supervisor_pkg::RST_OUT_EN;
    end else if (clk_en) begin
      power_fail_warn     <= raw_low_s;
      regulated_output_en <= on_s;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Guards qualify on clk_en, since a frozen cycle advances nothing
  halt_mirror_a: assert property (@(posedge clk) disable iff (!resetn)
      halt_n == reset_n)
    else $error("halt output differs from reset output");

  fault_reset_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && fault |=> !reset_n)
    else $error("reset not asserted during a supply fault");

  wd_timeout_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && timed_out && !fault |=> !reset_n && in_hold)
    else $error("watchdog timeout did not assert reset");

  hold_release_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && hold_done && !fault |=> reset_n && in_run)
    else $error("reset not released after the restart hold");

  init_release_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && init_done && !fault |=> reset_n && in_run)
    else $error("reset not released after the power-up hold");

  kick_rearm_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && run_kick && !fault |=> in_run && elapsed == '0)
    else $error("kick edge did not restart the timeout");

  uv_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && uv_q && release_s |=> uv_q)
    else $error("undervoltage cleared below the release level");

  uv_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !trip_s && !release_s |=> !uv_q)
    else $error("undervoltage held above the release level");

  warn_follow_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en |=> power_fail_warn == $past(raw_low_s))
    else $error("warning output does not follow the raw supply level");

  standby_off_a: assert property (@(posedge clk) disable iff (!resetn)
      clk_en && !on_s |=> !regulated_output_en)
    else $error("output left on in standby");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  // Main scenarios: power-up release, timeout, restart, standby
  init_seen_c: cover property (@(posedge clk) disable iff (!resetn)
    clk_en && init_done);
  timeout_seen_c: cover property (@(posedge clk) disable iff (!resetn)
    clk_en && timed_out);
  restart_seen_c: cover property (@(posedge clk) disable iff (!resetn)
    clk_en && hold_done);
  standby_seen_c: cover property (@(posedge clk) disable iff (!resetn)
    clk_en && standby && in_power_up);

endmodule // supply_supervisor_watchdog
`default_nettype wire

/* File: core/supervisor_pkg.sv */
// Constants shared by the supply supervisor and its helpers.
// Assumes a single 100 MHz clock; all delays are counts of that clock.
package supervisor_pkg;

  // ---------------------------------------------------------------
  // Clock rate
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;             // Cycles per microsecond

  // ---------------------------------------------------------------
  // Nominal times, in microseconds
  // ---------------------------------------------------------------
  localparam int T_INIT_US    = 30000;      // Power-up hold, 30 ms
  localparam int T_TIMEOUT_US = 7000;       // Watchdog timeout, 7 ms
  localparam int T_REINIT_US  = 6000;       // Reinit hold, 6 ms
  localparam int T_CYCLE_US   = 13000;      // Restart cycle, 13 ms
  localparam int T_KICK_US    = 20;         // Least kick pulse, 20 us

  // ---------------------------------------------------------------
  // Derived cycle counts
  // ---------------------------------------------------------------
  localparam int INIT_CYCLES    = T_INIT_US * CLK_MHZ;
  localparam int TIMEOUT_CYCLES = T_TIMEOUT_US * CLK_MHZ;
  localparam int REINIT_CYCLES  = T_REINIT_US * CLK_MHZ;
  localparam int CYCLE_CYCLES   = T_CYCLE_US * CLK_MHZ;
  localparam int KICK_CYCLES    = T_KICK_US * CLK_MHZ;

  // Counter width; 2**23 covers the 30 ms hold
  localparam int CNT_W = 23;

  // ---------------------------------------------------------------
  // Sync input bit positions
  // ---------------------------------------------------------------
  localparam int SYN_KICK    = 0;
  localparam int SYN_ON      = 1;
  localparam int SYN_TRIP    = 2;
  localparam int SYN_RELEASE = 3;
  localparam int SYN_ADJ     = 4;
  localparam int SYN_RAW     = 5;
  localparam int SYN_W       = 6;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic RST_RESET_N = 1'b0;     // Processor held in reset
  localparam logic RST_WARN    = 1'b0;
  localparam logic RST_OUT_EN  = 1'b0;     // Output off until sampled
  localparam logic RST_UV      = 1'b1;     // Assume undervoltage

  // ---------------------------------------------------------------
  // Supervisor states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWER_UP = 3'h1,
    ST_RUN      = 3'h2,
    ST_WD_HOLD  = 3'h4
  } sup_state_type;

endpackage

/* File: core/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  // Elaboration check
  if (W < 1) begin : g_bad_w
    $error("pin group must be at least one bit wide");
  end

  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= '0;
      level  <= '0;
    end else if (clk_en) begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end

endmodule // pin_sync
`default_nettype wire

/* File: core/delay_counter.sv */
// Saturating up-counter that measures time since the last clear.
// Assumes the owner compares the count against its own limits.
`timescale 1ns/1ps
`default_nettype none
module delay_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic         clear,
  output logic      [W-1:0] count
);

  // Elaboration check
  if (W < 1) begin : g_bad_w
    $error("counter must be at least one bit wide");
  end

  // ---------------------------------------------------------------
  // Count logic
  // ---------------------------------------------------------------
  wire         at_max  = (count == {W{1'b1}});
  wire [W-1:0] count_d = clear ? '0 : (at_max ? count : count + 1'b1);

  // Saturation stops a wrap from faking a short interval
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= '0;
    end else if (clk_en) begin
      count <= count_d;
    end
  end

endmodule // delay_counter
`default_nettype wire

/* File: tb/cpu_model.sv */
// Processor model on the far side: kicks the watchdog while it runs.
// Assumes the bench clock; kick period and width vary from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic halt_n,
  input  wire logic kick_en,
  output logic      watchdog_kick
);
  int seed   = 14700;
  int cnt    = 0;
  int period = 40;
  int width  = 8;
  initial watchdog_kick = 1'b0;
  // A processor held in reset or halt makes no kicks; the line keeps its level
  always @(posedge clk) begin
    if (!(reset_n && halt_n && kick_en)) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
      if (cnt == 0) watchdog_kick <= 1'b1;
      if (cnt == width) watchdog_kick <= 1'b0;
      if (cnt == period - 1) begin
        cnt    <= 0;
        period <= 30 + ($random(seed) & 32'h7FFF) % 50;
        width  <= 4 + ($random(seed) & 32'h7FFF) % 20;
      end
    end
  end
endmodule // cpu_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench: power-up, watchdog restart, supply faults, standby.
// Assumes the design files and the processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // Short delays keep the run brief
  // ---------------------------------------------------------------
  localparam int INIT = 200;
  localparam int TMO  = 100;
  localparam int RIN  = 60;
  typedef struct {logic [2:0] v; int t;} note_type;
  logic clk = 1'b0, resetn = 1'b0, kick_en = 1'b0, on_control = 1'b1;
  logic trip = 1'b0, rel = 1'b0, reg_low = 1'b0, raw_low = 1'b0;
  logic watchdog_kick, reset_n, halt_n, power_fail_warn, regulated_output_en;
  wire logic [2:0] cur = {reset_n, power_fail_warn, regulated_output_en};
  logic [2:0] prev;
  note_type q[$];
  note_type e;
  int mismatches = 0, n_checks = 0, cyc = 0, last = 0;

  supply_supervisor_watchdog #(.INIT_CYCLES(INIT), .TIMEOUT_CYCLES(TMO), .REINIT_CYCLES(RIN))
    supply_supervisor_watchdog_inst (.clk(clk), .resetn(resetn), .clk_en(1'b1),
    .watchdog_kick(watchdog_kick), .on_control(on_control), .out_below_trip(trip),
    .out_below_release(rel), .regulator_supply_low(reg_low), .raw_supply_sense_low(raw_low),
    .reset_n(reset_n), .halt_n(halt_n), .power_fail_warn(power_fail_warn),
    .regulated_output_en(regulated_output_en));
  cpu_model cpu_model_inst (.clk(clk), .reset_n(reset_n), .halt_n(halt_n), .kick_en(kick_en),
    .watchdog_kick(watchdog_kick));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic note(input logic [2:0] v, input int t);
    q.push_back('{v, t});
  endtask
  // Bounded wait for all noted output changes
  task automatic drain();
    int n = 0;
    while (q.size() > 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (q.size() > 0) check(3'h0, 3'h1, "output change missing");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Monitor: each output change takes the oldest note; reset edges timed
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!resetn) begin
      prev <= cur;
      last <= cyc;
    end else if (cur !== prev) begin
      prev <= cur;
      if (q.size() == 0) begin
        check(3'h0, 3'h1, "unexpected output change");
      end else begin
        e = q.pop_front();
        check(cur, e.v, "output levels");
        check({2'h0, halt_n}, {2'h0, reset_n}, "halt differs");
        if (cur[2] !== prev[2]) begin
          if (e.t > 0) check({2'h0, cyc - last >= e.t - 2 && cyc - last <= e.t + 8}, 3'h1, "timing");
          last <= cyc;
        end
      end
    end
  end

  // Watchdog against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    note(3'h1, 0);
    note(3'h5, INIT);
    drain();
    kick_en <= 1'b1;
    repeat (500) @(posedge clk);
    // Kicks stop: reset repeats once per restart cycle
    kick_en <= 1'b0;
    note(3'h1, 0);
    note(3'h5, RIN);
    note(3'h1, TMO);
    note(3'h5, RIN);
    repeat (1500) if (q.size() > 1) @(posedge clk);
    kick_en <= 1'b1;
    drain();
    repeat (400) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      raw_low <= ~raw_low;
      note({1'b1, ~raw_low, 1'b1}, 0);
      drain();
    end
    // Output sags past the release level first, then the trip level
    rel <= 1'b1;
    repeat (20) @(posedge clk);
    trip <= 1'b1;
    note(3'h1, 0);
    drain();
    trip <= 1'b0;
    repeat (INIT + 50) @(posedge clk);
    on_control <= 1'b0;
    note(3'h0, 0);
    drain();
    on_control <= 1'b1;
    note(3'h1, 0);
    drain();
    rel <= 1'b0;
    note(3'h5, 0);
    drain();
    repeat (300) @(posedge clk);
    reg_low <= 1'b1;
    note(3'h1, 0);
    drain();
    reg_low <= 1'b0;
    note(3'h5, 0);
    drain();
    repeat (300) @(posedge clk);
    results();
  end
endmodule // tb
`default_nettype wire
